// ---- hdl/hbt_blink.sv ----
`timescale 1ns/100ps
`default_nettype none
module hbt_blink #(
  parameter int HALF_CYC = 12500000,
  parameter int HOLD_CYC = 25000000
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic act_i,
  output logic led_o
);
  logic [31:0] hold_ff, nxt_hold;
  logic [31:0] div_ff, nxt_div;
  logic phase_ff, nxt_phase;
  logic led_ff, nxt_led;

  if (HALF_CYC < 1 || HOLD_CYC < 1) begin : g_bad
    $error("hbt_blink: counts must be positive");
  end

  // retriggerable hold window, led toggles inside it
  always_comb begin
    nxt_hold = (hold_ff != 32'h0) ? hold_ff - 32'h1 : 32'h0;
    nxt_div = div_ff;
    nxt_phase = phase_ff;
    if (act_i) begin
      nxt_hold = 32'(HOLD_CYC);
    end
    if (nxt_hold == 32'h0) begin
      nxt_div = 32'h0;
      nxt_phase = 1'b1;
    end else if (div_ff >= 32'(HALF_CYC - 1)) begin
      nxt_div = 32'h0;
      nxt_phase = !phase_ff;
    end else begin
      nxt_div = div_ff + 32'h1;
    end
    nxt_led = (nxt_hold != 32'h0) && nxt_phase; // see R12 see R13
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_ff <= 32'h0;
      div_ff <= 32'h0;
      phase_ff <= 1'b1;
      led_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      div_ff <= nxt_div;
      phase_ff <= nxt_phase;
      led_ff <= nxt_led;
    end
  end

  assign led_o = led_ff;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_led_quiet: assert property (hold_ff == 32'h0 |-> !led_ff) // see R12 see R13
    else $error("indicator lit without recent activity");
  chk_led_start: assert property (act_i && hold_ff == 32'h0 |=> led_ff) // see R12 see R13
    else $error("indicator not lit after activity");
endmodule // hbt_blink
`default_nettype wire

// ---- hdl/hbt_defs.svh ----
// Function
// R1: send scanner strings as single or block telegrams, paced by the protocol timeout.
// R2: append pending strings as blocks until timeout expires or maximum length reached.
// R3: blocks that do not fit stay buffered for the following telegram.
// R4: never split one scanner string across two telegrams.
// R5: software sets maximum telegram length above the longest scanner string.
// R6: each block starts with two ASCII decimal digits of its character count.
// R7: a block longer than 99 characters gets length field 00.
// R8: each block ends with the configured separator of up to five characters.
// R9: block telegram enclosed by start and stop characters, blocks in buffer order.
// R10: length counts all block characters; maximum length includes start and stop.
// R11: prefix two-digit device number and address separator; 00 hex omits separator.
// R12: blink host-data indicator while transmitting to host in network mode.
// R13: blink network-receive indicator while scanner data is being received.
// R14: ready indicator lit after passed self-test in network mode, off otherwise.
`ifndef HBT_DEFS_SVH
`define HBT_DEFS_SVH

`define HBT_IDX_CTRL 3'h0
`define HBT_IDX_MAXLEN 3'h1
`define HBT_IDX_CHARS 3'h2
`define HBT_IDX_SEPA 3'h3
`define HBT_IDX_SEPB 3'h4
`define HBT_IDX_TMO 3'h5
`define HBT_IDX_STAT 3'h6

`define HBT_CTRL_NET 0
`define HBT_CTRL_BLK 1
`define HBT_SEPB_CNT_LSB 8
`define HBT_ST_USED_LSB 8
`define HBT_ST_BUSY 24
`define HBT_ST_READY 25

`define HBT_RST_MAXLEN 9'h064
`define HBT_RST_START 8'h02
`define HBT_RST_STOP 8'h03
`define HBT_RST_ASEP 8'h7d
`define HBT_RST_SEP 40'h000000000d
`define HBT_RST_SEPCNT 3'h1
`define HBT_RST_TMO 16'h0100

`define HBT_SEP_MAX 3'h5
`define HBT_ASCII0 8'h30
`define HBT_TEN 9'h00a
`define HBT_LEN_MAX2 9'h063
`define HBT_FRAME_LEN 9'h002
`define HBT_HDR_BASE 9'h004

`define HBT_CLK_KHZ 250000
`define HBT_BLINK_MS 50
`define HBT_HOLD_MS 100

`endif

// ---- hdl/hbt_framer.sv ----
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "hbt_defs.svh"
module hbt_framer import hbt_pkg::*; #(
  parameter int MEM_AW = 8,
  parameter int DESC_AW = 3,
  parameter int BLINK_CYC = `HBT_BLINK_MS * `HBT_CLK_KHZ,
  parameter int HOLD_CYC = `HBT_HOLD_MS * `HBT_CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  input wire logic in_last_i,
  input wire logic [5:0] in_addr_i,
  output logic in_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic selftest_done_i,
  input wire logic selftest_ok_i,
  output logic led_data_o,
  output logic led_rx_o,
  output logic led_ready_o
);
  localparam int DEPTH = 2 ** MEM_AW;
  localparam int DDEPTH = 2 ** DESC_AW;

  if (MEM_AW < 4 || MEM_AW > 16 || DESC_AW < 1 || DESC_AW > 6) begin : g_bad
    $error("hbt_framer: unsupported buffer size");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] digit(input logic [8:0] v, input logic tens);
    logic [8:0] d;
    d = tens ? (v / `HBT_TEN) : (v % `HBT_TEN);
    return `HBT_ASCII0 + d[7:0];
  endfunction

  hbt_cfg_t cfg_ff, nxt_cfg;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  hbt_desc_t desc_ff [DDEPTH];
  hbt_desc_t nxt_desc [DDEPTH];
  logic [MEM_AW:0] wrp_ff, nxt_wrp, rdp_ff, nxt_rdp;
  logic [DESC_AW:0] dw_ff, nxt_dw, dr_ff, nxt_dr;
  logic [7:0] cur_len_ff, nxt_cur_len;
  logic in_rdy_ff, nxt_in_rdy;
  hbt_state_t st_ff, nxt_st;
  logic [7:0] rem_ff, nxt_rem;
  logic [2:0] sidx_ff, nxt_sidx;
  logic [8:0] tlen_ff, nxt_tlen;
  logic [15:0] timer_ff, nxt_timer;
  logic pend_ff, nxt_pend;
  logic txv_ff, nxt_txv;
  logic [7:0] txd_ff, nxt_txd;
  logic st_ok_ff, nxt_st_ok;
  logic rdy_led_ff, nxt_rdy_led;

  logic wb_go, wr_go, accept, pop, mem_re, can_load;
  logic [7:0] mem_rd;
  logic [31:0] w;
  logic [DESC_AW:0] dcnt;
  logic [MEM_AW:0] used;
  hbt_desc_t hd;
  logic [8:0] hd_blen;

  assign dcnt = dw_ff - dr_ff;
  assign used = wrp_ff - rdp_ff;
  assign hd = desc_ff[dr_ff[DESC_AW-1:0]];
  // every character of the block counts // see R10
  assign hd_blen = `HBT_HDR_BASE + {8'h0, cfg_ff.asep_ch != 8'h0} + {1'b0, hd.len}
                   + {6'h0, cfg_ff.sep_cnt};
  assign can_load = !txv_ff || tx_ready_i;
  assign accept = in_valid_i && in_rdy_ff;

  // register bus: ack one cycle after request, write lands at the ack edge
  always_comb begin
    wb_go = wb_cyc_i && wb_stb_i;
    wr_go = wb_go && ack_ff && wb_we_i && (wb_adr_i[7:5] == 3'h0);
    nxt_ack = wb_go && !ack_ff;
    nxt_cfg = cfg_ff;
    nxt_rdat = rdat_ff;
    w = 32'h0;
    if (wr_go) begin
      unique case (wb_adr_i[4:2])
        `HBT_IDX_CTRL: begin
          w = merge({30'h0, cfg_ff.blk_mode, cfg_ff.net_mode}, wb_dat_i, wb_sel_i);
          nxt_cfg.net_mode = w[`HBT_CTRL_NET];
          nxt_cfg.blk_mode = w[`HBT_CTRL_BLK];
        end
        `HBT_IDX_MAXLEN: begin
          w = merge({23'h0, cfg_ff.max_len}, wb_dat_i, wb_sel_i);
          nxt_cfg.max_len = w[8:0];
        end
        `HBT_IDX_CHARS: begin
          w = merge({8'h0, cfg_ff.asep_ch, cfg_ff.stop_ch, cfg_ff.start_ch}, wb_dat_i,
                    wb_sel_i);
          nxt_cfg.start_ch = w[7:0];
          nxt_cfg.stop_ch = w[15:8];
          nxt_cfg.asep_ch = w[23:16];
        end
        `HBT_IDX_SEPA: begin
          w = merge(cfg_ff.sep_chs[31:0], wb_dat_i, wb_sel_i);
          nxt_cfg.sep_chs[31:0] = w;
        end
        `HBT_IDX_SEPB: begin
          w = merge({21'h0, cfg_ff.sep_cnt, cfg_ff.sep_chs[39:32]}, wb_dat_i, wb_sel_i);
          nxt_cfg.sep_chs[39:32] = w[7:0];
          // separator length clamps at five // see R8
          nxt_cfg.sep_cnt = (w[10:8] > `HBT_SEP_MAX) ? `HBT_SEP_MAX : w[10:8];
        end
        `HBT_IDX_TMO: begin
          w = merge({16'h0, cfg_ff.tmo}, wb_dat_i, wb_sel_i);
          nxt_cfg.tmo = w[15:0];
        end
        default: begin
        end
      endcase
    end
    if (nxt_ack) begin
      nxt_rdat = 32'h0;
      if (wb_adr_i[7:5] == 3'h0) begin
        unique case (wb_adr_i[4:2])
          `HBT_IDX_CTRL: nxt_rdat = {30'h0, cfg_ff.blk_mode, cfg_ff.net_mode};
          `HBT_IDX_MAXLEN: nxt_rdat = {23'h0, cfg_ff.max_len};
          `HBT_IDX_CHARS: nxt_rdat = {8'h0, cfg_ff.asep_ch, cfg_ff.stop_ch, cfg_ff.start_ch};
          `HBT_IDX_SEPA: nxt_rdat = cfg_ff.sep_chs[31:0];
          `HBT_IDX_SEPB: nxt_rdat = {21'h0, cfg_ff.sep_cnt, cfg_ff.sep_chs[39:32]};
          `HBT_IDX_TMO: nxt_rdat = {16'h0, cfg_ff.tmo};
          `HBT_IDX_STAT: begin
            nxt_rdat = 32'(dcnt) | (32'(used) << `HBT_ST_USED_LSB);
            nxt_rdat[`HBT_ST_BUSY] = (st_ff != HBT_IDLE);
            nxt_rdat[`HBT_ST_READY] = rdy_led_ff;
          end
          default: nxt_rdat = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
      cfg_ff.net_mode <= 1'b0;
      cfg_ff.blk_mode <= 1'b0;
      cfg_ff.max_len <= `HBT_RST_MAXLEN;
      cfg_ff.start_ch <= `HBT_RST_START;
      cfg_ff.stop_ch <= `HBT_RST_STOP;
      cfg_ff.asep_ch <= `HBT_RST_ASEP;
      cfg_ff.sep_chs <= `HBT_RST_SEP;
      cfg_ff.sep_cnt <= `HBT_RST_SEPCNT;
      cfg_ff.tmo <= `HBT_RST_TMO;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      cfg_ff <= nxt_cfg;
    end
  end

  // collect strings; descriptor pushed with the last byte
  always_comb begin
    nxt_wrp = wrp_ff;
    nxt_dw = dw_ff;
    nxt_cur_len = cur_len_ff;
    nxt_desc = desc_ff;
    if (accept) begin
      nxt_wrp = wrp_ff + (MEM_AW+1)'(1);
      nxt_cur_len = in_last_i ? 8'h0 : cur_len_ff + 8'h1;
      if (in_last_i) begin
        nxt_desc[dw_ff[DESC_AW-1:0]] = '{addr: in_addr_i, len: cur_len_ff + 8'h1};
        nxt_dw = dw_ff + (DESC_AW+1)'(1);
      end
    end
    nxt_dr = pop ? dr_ff + (DESC_AW+1)'(1) : dr_ff; // see R3
    nxt_rdp = mem_re ? rdp_ff + (MEM_AW+1)'(1) : rdp_ff;
    nxt_in_rdy = ((nxt_wrp - nxt_rdp) < (MEM_AW+1)'(DEPTH - 2))
                 && ((nxt_dw - nxt_dr) < (DESC_AW+1)'(DDEPTH - 1));
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wrp_ff <= '0;
      rdp_ff <= '0;
      dw_ff <= '0;
      dr_ff <= '0;
      cur_len_ff <= 8'h0;
      in_rdy_ff <= 1'b0;
      for (int i = 0; i < DDEPTH; i++) begin
        desc_ff[i] <= '0;
      end
    end else begin
      wrp_ff <= nxt_wrp;
      rdp_ff <= nxt_rdp;
      dw_ff <= nxt_dw;
      dr_ff <= nxt_dr;
      cur_len_ff <= nxt_cur_len;
      in_rdy_ff <= nxt_in_rdy;
      desc_ff <= nxt_desc;
    end
  end

  hbt_mem #(.DW(8), .AW(MEM_AW)) u_mem (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .we_i(accept),
    .waddr_i(wrp_ff[MEM_AW-1:0]),
    .wdata_i(in_data_i),
    .re_i(mem_re),
    .raddr_i(rdp_ff[MEM_AW-1:0]),
    .rdata_o(mem_rd)
  );

  // telegram sequencer, one character per load
  always_comb begin
    nxt_st = st_ff;
    nxt_rem = rem_ff;
    nxt_sidx = sidx_ff;
    nxt_tlen = tlen_ff;
    nxt_pend = pend_ff;
    nxt_txv = txv_ff && !tx_ready_i;
    nxt_txd = txd_ff;
    nxt_timer = (timer_ff != 16'h0) ? timer_ff - 16'h1 : 16'h0;
    mem_re = 1'b0;
    pop = 1'b0;
    unique case (st_ff)
      HBT_IDLE: begin
        // next telegram only once the protocol timeout ran out // see R1
        if (cfg_ff.net_mode && dcnt != '0 && timer_ff == 16'h0) begin
          nxt_timer = cfg_ff.tmo;
          nxt_tlen = `HBT_FRAME_LEN + (cfg_ff.blk_mode ? hd_blen : 9'h0); // see R10
          nxt_st = HBT_START;
        end
      end
      HBT_START: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = cfg_ff.start_ch; // see R9
        nxt_st = cfg_ff.blk_mode ? HBT_LEN1 : HBT_ADR1;
      end
      HBT_LEN1: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = (hd_blen > `HBT_LEN_MAX2) ? `HBT_ASCII0 : digit(hd_blen, 1'b1); // see R6 see R7
        nxt_st = HBT_LEN0;
      end
      HBT_LEN0: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = (hd_blen > `HBT_LEN_MAX2) ? `HBT_ASCII0 : digit(hd_blen, 1'b0); // see R6 see R7
        nxt_st = HBT_ADR1;
      end
      HBT_ADR1: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = digit({3'h0, hd.addr}, 1'b1); // see R11
        nxt_st = HBT_ADR0;
      end
      HBT_ADR0: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = digit({3'h0, hd.addr}, 1'b0); // see R11
        nxt_rem = hd.len;
        nxt_st = (cfg_ff.asep_ch != 8'h0) ? HBT_ASEP : HBT_DATA; // see R11
      end
      HBT_ASEP: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = cfg_ff.asep_ch; // see R11
        nxt_st = HBT_DATA;
      end
      HBT_DATA: begin
        if (!pend_ff) begin
          mem_re = 1'b1;
          nxt_pend = 1'b1;
        end else if (can_load) begin
          nxt_txv = 1'b1;
          nxt_txd = mem_rd;
          nxt_pend = 1'b0;
          nxt_rem = rem_ff - 8'h1;
          if (rem_ff == 8'h1) begin
            // string fully sent before its descriptor is released // see R4
            pop = 1'b1;
            nxt_sidx = 3'h0;
            if (!cfg_ff.blk_mode) begin
              nxt_st = HBT_STOP;
            end else begin
              nxt_st = (cfg_ff.sep_cnt != 3'h0) ? HBT_BSEP : HBT_CHK;
            end
          end
        end
      end
      HBT_BSEP: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = cfg_ff.sep_chs[{sidx_ff, 3'h0} +: 8]; // see R8
        nxt_sidx = sidx_ff + 3'h1;
        if (sidx_ff == cfg_ff.sep_cnt - 3'h1) begin
          nxt_st = HBT_CHK;
        end
      end
      HBT_CHK: begin
        // append while time remains and the block fits, else keep it // see R2 see R3
        // sum one bit wider so a long block cannot wrap into a false fit
        if (dcnt != '0 && timer_ff != 16'h0
            && ({1'b0, tlen_ff} + {1'b0, hd_blen}) <= {1'b0, cfg_ff.max_len}) begin
          nxt_tlen = tlen_ff + hd_blen; // see R10
          nxt_st = HBT_LEN1;
        end else begin
          nxt_st = HBT_STOP;
        end
      end
      HBT_STOP: if (can_load) begin
        nxt_txv = 1'b1;
        nxt_txd = cfg_ff.stop_ch; // see R9
        nxt_st = HBT_IDLE;
      end
      default: nxt_st = HBT_IDLE;
    endcase
    nxt_st_ok = st_ok_ff || (selftest_done_i && selftest_ok_i);
    nxt_rdy_led = nxt_st_ok && nxt_cfg.net_mode; // see R14
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= HBT_IDLE;
      rem_ff <= 8'h0;
      sidx_ff <= 3'h0;
      tlen_ff <= 9'h0;
      timer_ff <= 16'h0;
      pend_ff <= 1'b0;
      txv_ff <= 1'b0;
      txd_ff <= 8'h0;
      st_ok_ff <= 1'b0;
      rdy_led_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      rem_ff <= nxt_rem;
      sidx_ff <= nxt_sidx;
      tlen_ff <= nxt_tlen;
      timer_ff <= nxt_timer;
      pend_ff <= nxt_pend;
      txv_ff <= nxt_txv;
      txd_ff <= nxt_txd;
      st_ok_ff <= nxt_st_ok;
      rdy_led_ff <= nxt_rdy_led;
    end
  end

  hbt_blink #(.HALF_CYC(BLINK_CYC), .HOLD_CYC(HOLD_CYC)) u_led_data (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .act_i(txv_ff && tx_ready_i && cfg_ff.net_mode), // see R12
    .led_o(led_data_o)
  );

  hbt_blink #(.HALF_CYC(BLINK_CYC), .HOLD_CYC(HOLD_CYC)) u_led_rx (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .act_i(accept), // see R13
    .led_o(led_rx_o)
  );

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign in_ready_o = in_rdy_ff;
  assign tx_valid_o = txv_ff;
  assign tx_data_o = txd_ff;
  assign led_ready_o = rdy_led_ff;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_stop_sent;
    st_ff == HBT_STOP && can_load ##1 txv_ff && txd_ff == $past(cfg_ff.stop_ch);
  endsequence

  chk_start_first: assert property (st_ff == HBT_START && can_load |=> // see R9
      txv_ff && txd_ff == $past(cfg_ff.start_ch))
    else $error("start character not emitted");
  chk_stop_last: assert property (st_ff == HBT_STOP && can_load |-> // see R9
      s_stop_sent ##0 st_ff == HBT_IDLE)
    else $error("stop character not emitted");
  chk_len_over: assert property (st_ff == HBT_LEN1 && can_load && hd_blen > 9'h063 |=> // see R7
      txd_ff == 8'h30)
    else $error("oversize block length not 00");
  chk_len_tens: assert property (st_ff == HBT_LEN1 && can_load && hd_blen <= 9'h063 |=> // see R6
      txd_ff == 8'h30 + 8'($past(hd_blen) / 9'h00a))
    else $error("length tens digit wrong");
  chk_no_split: assert property (st_ff == HBT_DATA ##1 st_ff != HBT_DATA |-> // see R4
      rem_ff == 8'h0)
    else $error("string left before its last character");
  chk_pop_cause: assert property (dr_ff != $past(dr_ff) |-> $past(st_ff) == HBT_DATA) // see R3
    else $error("pending string dropped without being sent");
  chk_append_fit: assert property (st_ff == HBT_CHK ##1 st_ff == HBT_LEN1 |-> // see R2
      tlen_ff <= cfg_ff.max_len && $past(timer_ff) != 16'h0)
    else $error("block appended past limit or timeout");
  chk_addr_sep: assert property (st_ff == HBT_ASEP |-> cfg_ff.asep_ch != 8'h0) // see R11
    else $error("address separator emitted while disabled");
  chk_sep_first: assert property (st_ff == HBT_BSEP && can_load && sidx_ff == 3'h0 |=> // see R8
      txd_ff == $past(cfg_ff.sep_chs[7:0]))
    else $error("block separator wrong");
  chk_paced: assert property (st_ff == HBT_IDLE ##1 st_ff == HBT_START |-> // see R1
      timer_ff == $past(cfg_ff.tmo) && $past(cfg_ff.net_mode))
    else $error("telegram started without pacing");
  chk_ready_led: assert property (!cfg_ff.net_mode ##1 !cfg_ff.net_mode |-> !led_ready_o) // see R14
    else $error("ready indicator lit outside network mode");
endmodule // hbt_framer
`default_nettype wire

// ---- hdl/hbt_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module hbt_mem #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_ff [2**AW];
  logic [DW-1:0] rdata_ff;

  if (AW < 2 || DW < 1) begin : g_bad
    $error("hbt_mem: unsupported size");
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= '0;
    end else if (re_i) begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule // hbt_mem
`default_nettype wire

// ---- hdl/hbt_pkg.sv ----
`include "hbt_defs.svh"
package hbt_pkg;

  typedef struct packed {
    logic net_mode;
    logic blk_mode;
    logic [8:0] max_len;
    logic [7:0] start_ch;
    logic [7:0] stop_ch;
    logic [7:0] asep_ch;
    logic [39:0] sep_chs;
    logic [2:0] sep_cnt;
    logic [15:0] tmo;
  } hbt_cfg_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] len;
  } hbt_desc_t;

  typedef enum logic [10:0] {
    HBT_IDLE = 11'h001,
    HBT_START = 11'h002,
    HBT_LEN1 = 11'h004,
    HBT_LEN0 = 11'h008,
    HBT_ADR1 = 11'h010,
    HBT_ADR0 = 11'h020,
    HBT_ASEP = 11'h040,
    HBT_DATA = 11'h080,
    HBT_BSEP = 11'h100,
    HBT_CHK = 11'h200,
    HBT_STOP = 11'h400
  } hbt_state_t;

endpackage

// ---- sim/hbt_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module hbt_host (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] rxq[$];
  logic ph;

  // slow host accepts only every other cycle
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_ready_o <= 1'b0;
      ph <= 1'b0;
    end else begin
      if (tx_valid_i === 1'b1 && tx_ready_o) rxq.push_back(tx_data_i);
      ph <= ~ph;
      tx_ready_o <= !slow_i || ph;
    end
  end
endmodule // hbt_host
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d;} hbt_row_t;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, iv = 1'b0, il = 1'b0;
  logic sd = 1'b0, so = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00, idat = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, wb_dat_o;
  logic [5:0] ia = 6'h00;
  logic wb_ack_o, in_ready_o, tx_valid_o, tx_ready, led_data_o, led_rx_o, led_ready_o;
  logic [7:0] tx_data_o;
  int bad_count = 0, cmp_count = 0, cyc_n = 0, sepn = 1;
  logic saw_rx = 1'b0, saw_data = 1'b0;
  logic [7:0] eq[$];
  logic [7:0] asep = 8'h7d;
  logic [7:0] sep[5] = '{8'h0d, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0] wsel = 4'hf;
  hbt_row_t rows[9] = '{'{8'h00, 32'h0}, '{8'h04, 32'h64}, '{8'h08, 32'h007d0302},
    '{8'h0c, 32'h0d}, '{8'h10, 32'h100}, '{8'h14, 32'h100}, '{8'h18, 32'h0}, '{8'h1c, 32'h0},
    '{8'h20, 32'h0}};

  always #2 clk_i = ~clk_i;

  hbt_framer #(.BLINK_CYC(4), .HOLD_CYC(16)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .in_valid_i(iv), .in_data_i(idat), .in_last_i(il), .in_addr_i(ia),
    .in_ready_o(in_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready), .selftest_done_i(sd), .selftest_ok_i(so),
    .led_data_o(led_data_o), .led_rx_o(led_rx_o), .led_ready_o(led_ready_o));

  hbt_host host (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready));

  task complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n++;
    if (led_rx_o === 1'b1) saw_rx = 1'b1;
    if (led_data_o === 1'b1) saw_data = 1'b1;
    if (cyc_n == 40000) begin
      bad_count++;
      complete_run;
    end
  end

  task chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t word %h expected %h", $time, g, e);
    end
  endtask

  task chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t char %h expected %h", $time, g, e);
    end
  endtask

  task chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= wsel;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [7:0] pb(input int i);
    return 8'h41 + 8'(i % 26);
  endfunction

  // n above zero sends a generated payload of n bytes instead of s
  task send(input logic [5:0] a, input string s, input int n);
    int len;
    len = (n > 0) ? n : s.len();
    for (int i = 0; i < len; i++) begin
      iv <= 1'b1;
      idat <= (n > 0) ? pb(i) : 8'(s[i]);
      il <= (i == len - 1);
      ia <= a;
      @(posedge clk_i);
      while (in_ready_o !== 1'b1) @(posedge clk_i);
    end
    iv <= 1'b0;
    idat <= ~idat;
    il <= 1'b0;
    @(posedge clk_i);
  endtask

  task blk(input logic [5:0] a, input string s, input int n, input bit b);
    int len, ll;
    len = (n > 0) ? n : s.len();
    ll = 4 + ((asep != 8'h00) ? 1 : 0) + len + sepn;
    if (ll > 99) ll = 0;
    if (b) eq.push_back(8'h30 + 8'(ll / 10));
    if (b) eq.push_back(8'h30 + 8'(ll % 10));
    eq.push_back(8'h30 + 8'(a / 10));
    eq.push_back(8'h30 + 8'(a % 10));
    if (asep != 8'h00) eq.push_back(asep);
    for (int i = 0; i < len; i++) eq.push_back((n > 0) ? pb(i) : 8'(s[i]));
    for (int i = 0; b && i < sepn; i++) eq.push_back(sep[i]);
  endtask

  task expect_tx;
    int t;
    t = 0;
    while (host.rxq.size() < eq.size() && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    repeat (20) @(posedge clk_i);
    chk32(host.rxq.size(), eq.size());
    for (int i = 0; i < eq.size() && i < host.rxq.size(); i++) chk8(host.rxq[i], eq[i]);
    eq.delete();
    host.rxq.delete();
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0);
      chk32(rd, rows[i].d);
    end
    wb(1'b1, 8'h18, 32'hffffffff);
    wb(1'b0, 8'h18, 32'h0);
    chk32(rd, 32'h0);
    // one byte lane only: stop character changes, the rest stays
    wsel = 4'h2;
    wb(1'b1, 8'h08, 32'hffff55ff);
    wsel = 4'hf;
    wb(1'b0, 8'h08, 32'h0);
    chk32(rd, 32'h007d5502);
    wb(1'b1, 8'h08, 32'h7d0302);
    wb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clk_i);
    chk1(led_ready_o, 1'b0);
    sd <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1(led_ready_o, 1'b0);
    so <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1(led_ready_o, 1'b1);
    // strings pile up while output is off
    wb(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge clk_i);
    chk1(led_ready_o, 1'b0);
    wb(1'b1, 8'h04, 32'd20);
    wb(1'b1, 8'h0c, 32'h53);
    sep[0] = 8'h53;
    send(6'd2, "12345678", 0);
    send(6'd3, "abc", 0);
    send(6'd2, "XYZ", 0);
    slow <= 1'b1;
    wb(1'b1, 8'h00, 32'h3);
    eq.push_back(8'h02);
    blk(6'd2, "12345678", 0, 1'b1);
    eq.push_back(8'h03);
    eq.push_back(8'h02);
    blk(6'd3, "abc", 0, 1'b1);
    blk(6'd2, "XYZ", 0, 1'b1);
    eq.push_back(8'h03);
    expect_tx;
    chk1(saw_rx, 1'b1);
    chk1(saw_data, 1'b1);
    // lone oversize block, no address separator, five-character separator
    slow <= 1'b0;
    asep = 8'h00;
    sepn = 5;
    sep = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
    wb(1'b1, 8'h08, 32'h0302);
    wb(1'b1, 8'h0c, 32'h44434241);
    wb(1'b1, 8'h10, 32'h545);
    wb(1'b1, 8'h04, 32'h1ff);
    send(6'd5, "", 100);
    eq.push_back(8'h02);
    blk(6'd5, "", 100, 1'b1);
    eq.push_back(8'h03);
    expect_tx;
    // single telegrams, highest device number
    asep = 8'h7d;
    wb(1'b1, 8'h08, 32'h7d0302);
    wb(1'b1, 8'h00, 32'h1);
    send(6'd2, "A", 0);
    send(6'd63, "B", 0);
    eq.push_back(8'h02);
    blk(6'd2, "A", 0, 1'b0);
    eq.push_back(8'h03);
    eq.push_back(8'h02);
    blk(6'd63, "B", 0, 1'b0);
    eq.push_back(8'h03);
    expect_tx;
    wb(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge clk_i);
    chk1(led_ready_o, 1'b0);
    // mid-run reset clears the self-test latch and the configuration
    sd <= 1'b0;
    so <= 1'b0;
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk1(led_ready_o, 1'b0);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clk_i);
    chk1(led_ready_o, 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk32(rd, 32'h64);
    complete_run;
  end
endmodule // tb
`default_nettype wire
